// ---- logic/csfr_status_regs.v ----
// charger status and fault register bank: three 8-bit registers at 0x08,
// 0x09 and 0x0a on the charger's internal register port, plus the two
// regulation interrupt pulses.
// assumes: the serial interface front end presents single-cycle read and
// write strobes with an 8-bit address; condition levels from the analog
// side are synchronous to mclk.

`include "csfr_defines.vh"

module csfr_status_regs #(
  parameter RELOAD_CYC = `CSFR_RELOAD_CYC
) (
  mclk,
  rst_n,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  reg_hit,
  reload_request,
  reload_busy,
  safety_timer_reset,
  source_onehot,
  in_precharge,
  in_fastcharge,
  charge_done,
  power_good,
  in_thermal_regulation,
  in_min_system_regulation,
  watchdog_expired,
  otg_overload,
  battery_too_low_for_boost,
  adapter_ov,
  vin_between_bat_and_min,
  thermal_shutdown,
  safety_timer_expired,
  battery_ov,
  boost_mode,
  zone_onehot,
  input_attached,
  in_vin_regulation,
  in_iin_regulation,
  topoff_counting,
  input_ov_state,
  vin_reg_irq,
  iin_reg_irq
);

  input wire mclk;
  input wire rst_n;
  input wire [7:0] reg_addr;
  input wire [7:0] reg_wdata;
  input wire reg_wr;
  input wire reg_rd;
  output reg [7:0] reg_rdata;
  output wire reg_hit;
  input wire reload_request;
  output wire reload_busy;
  output wire safety_timer_reset;
  input wire [6:0] source_onehot;
  input wire in_precharge;
  input wire in_fastcharge;
  input wire charge_done;
  input wire power_good;
  input wire in_thermal_regulation;
  input wire in_min_system_regulation;
  input wire watchdog_expired;
  input wire otg_overload;
  input wire battery_too_low_for_boost;
  input wire adapter_ov;
  input wire vin_between_bat_and_min;
  input wire thermal_shutdown;
  input wire safety_timer_expired;
  input wire battery_ov;
  input wire boost_mode;
  input wire [3:0] zone_onehot;
  input wire input_attached;
  input wire in_vin_regulation;
  input wire in_iin_regulation;
  input wire topoff_counting;
  input wire input_ov_state;
  output wire vin_reg_irq;
  output wire iin_reg_irq;

  ////////////////////////////////////////////////////////////////////////////
  // address decode, shared by read and write paths

  function [1:0] csfr_decode;
    input [7:0] addr;
    begin
      case (addr)
        `CSFR_ADDR_CHARGER_STATUS: csfr_decode = 2'h1;
        `CSFR_ADDR_FAULT_STATUS: csfr_decode = 2'h2;
        `CSFR_ADDR_INPUT_STATUS: csfr_decode = 2'h3;
        default: csfr_decode = 2'h0;
      endcase
    end
  endfunction

  wire [1:0] sel; // which register the address names, 0 for none
  assign sel = csfr_decode(reg_addr);
  assign reg_hit = (sel != 2'h0);

  ////////////////////////////////////////////////////////////////////////////
  // field encoders

  wire [2:0] source_code; // input source field
  wire [1:0] phase_code; // charge phase field
  wire [1:0] fault_code; // charge fault field
  wire [2:0] zone_code; // thermistor zone field

  csfr_code_map u_code_map (
    .source_onehot(source_onehot),
    .in_precharge(in_precharge),
    .in_fastcharge(in_fastcharge),
    .charge_done(charge_done),
    .adapter_ov(adapter_ov),
    .vin_between_bat_and_min(vin_between_bat_and_min),
    .thermal_shutdown(thermal_shutdown),
    .safety_timer_expired(safety_timer_expired),
    .boost_mode(boost_mode),
    .zone_onehot(zone_onehot),
    .source_code(source_code),
    .phase_code(phase_code),
    .fault_code(fault_code),
    .zone_code(zone_code)
  );

  ////////////////////////////////////////////////////////////////////////////
  // status capture: live levels are registered each cycle so a read sees
  // one coherent byte rather than bits changing mid-transfer

  reg [7:0] charger_status_q;
  reg [7:0] fault_status_q;
  reg [5:0] input_flags_q; // bits 7:2 of the third register
  reg [7:0] charger_status_d;
  reg [7:0] fault_status_d;
  reg [5:0] input_flags_d;
  wire boost_blocked; // anything that stops boost from starting

  assign boost_blocked = otg_overload || adapter_ov ||
                         battery_too_low_for_boost;

  // assemble the next status bytes
  always @* begin
    charger_status_d = 8'h00;
    // source field carries detection only, never the software limit
    charger_status_d[`CSFR_SRC_MSB:`CSFR_SRC_LSB] = source_code;
    charger_status_d[`CSFR_PHASE_MSB:`CSFR_PHASE_LSB] = phase_code;
    charger_status_d[`CSFR_PG_BIT] = power_good;
    charger_status_d[`CSFR_THERM_BIT] = in_thermal_regulation;
    charger_status_d[`CSFR_MINSYS_BIT] = in_min_system_regulation;
    fault_status_d = 8'h00;
    fault_status_d[`CSFR_WDOG_BIT] = watchdog_expired;
    fault_status_d[`CSFR_OTG_BIT] = boost_blocked;
    fault_status_d[`CSFR_CHGF_MSB:`CSFR_CHGF_LSB] = fault_code;
    fault_status_d[`CSFR_BATOV_BIT] = battery_ov;
    fault_status_d[`CSFR_ZONE_MSB:`CSFR_ZONE_LSB] = zone_code;
    input_flags_d = 6'h00;
    input_flags_d[5] = input_attached;
    input_flags_d[4] = in_vin_regulation;
    input_flags_d[3] = in_iin_regulation;
    input_flags_d[2] = 1'b0; // reserved, reads zero
    input_flags_d[1] = topoff_counting;
    input_flags_d[0] = input_ov_state;
  end

  // the status flops follow the conditions and are never written by software
  always @(posedge mclk) begin
    if (!rst_n) begin
      charger_status_q <= 8'h00;
      fault_status_q <= 8'h00;
      input_flags_q <= 6'h00;
    end else begin
      charger_status_q <= charger_status_d;
      fault_status_q <= fault_status_d;
      input_flags_q <= input_flags_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // defaults reload sequencer: a request starts a count; while it runs the
  // masks sit at default and the safety timer reset is held

  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;

  reg state_q;
  reg state_d;
  reg [7:0] reload_cnt_q;
  reg [7:0] reload_cnt_d;

  // count down the reload, then return to idle so the request bit clears
  always @* begin
    state_d = state_q;
    reload_cnt_d = reload_cnt_q;
    case (state_q)
      ST_IDLE: begin
        if (reload_request) begin
          state_d = ST_BUSY;
          reload_cnt_d = RELOAD_CYC[7:0] - 8'h01;
        end
      end
      ST_BUSY: begin
        if (reload_cnt_q == 8'h00) begin
          state_d = ST_IDLE;
        end else begin
          reload_cnt_d = reload_cnt_q - 8'h01;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      reload_cnt_q <= 8'h00;
    end else begin
      state_q <= state_d;
      reload_cnt_q <= reload_cnt_d;
    end
  end

  // busy reads back as the request bit still set; it drops when done
  assign reload_busy = (state_q == ST_BUSY);
  assign safety_timer_reset = (state_q == ST_BUSY);

  ////////////////////////////////////////////////////////////////////////////
  // interrupt masks, the only writable bits of these registers

  reg vin_mask_q;
  reg iin_mask_q;
  reg vin_mask_d;
  reg iin_mask_d;
  wire mask_write; // write to the third register
  assign mask_write = reg_wr && (sel == 2'h3);

  // reload wins over a write in the same cycle: defaults must stick
  always @* begin
    vin_mask_d = vin_mask_q;
    iin_mask_d = iin_mask_q;
    if (reload_request || reload_busy) begin
      vin_mask_d = `CSFR_MASK_RESET;
      iin_mask_d = `CSFR_MASK_RESET;
    end else if (mask_write) begin
      // only the two mask bits are taken; the rest of the byte is dropped
      vin_mask_d = reg_wdata[`CSFR_VMASK_BIT];
      iin_mask_d = reg_wdata[`CSFR_IMASK_BIT];
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      vin_mask_q <= `CSFR_MASK_RESET;
      iin_mask_q <= `CSFR_MASK_RESET;
    end else begin
      vin_mask_q <= vin_mask_d;
      iin_mask_q <= iin_mask_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // regulation entry pulses; edges taken from the captured flags so the
  // pulse lines up with the byte a read would return

  csfr_irq_pulse u_vin_pulse (
    .mclk(mclk),
    .rst_n(rst_n),
    .level(input_flags_q[4]),
    .mask(vin_mask_q),
    .pulse(vin_reg_irq)
  );

  csfr_irq_pulse u_iin_pulse (
    .mclk(mclk),
    .rst_n(rst_n),
    .level(input_flags_q[3]),
    .mask(iin_mask_q),
    .pulse(iin_reg_irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read data: registered, valid the cycle after the read strobe

  reg [7:0] rdata_d;

  // unmapped addresses read as zero
  always @* begin
    rdata_d = reg_rdata;
    if (reg_rd) begin
      case (sel)
        2'h1: rdata_d = charger_status_q;
        2'h2: rdata_d = fault_status_q;
        2'h3: rdata_d = {input_flags_q, vin_mask_q, iin_mask_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

endmodule

// ---- logic/csfr_defines.vh ----
// register offsets, field positions, reset values and timing counts for the
// charger status and fault register bank.
// assumes: included by bare name from the design files under logic/.
`ifndef CSFR_DEFINES_VH
`define CSFR_DEFINES_VH

// register addresses on the serial register port
`define CSFR_ADDR_CHARGER_STATUS 8'h08
`define CSFR_ADDR_FAULT_STATUS 8'h09
`define CSFR_ADDR_INPUT_STATUS 8'h0a

// charger_status field positions
`define CSFR_SRC_MSB 7
`define CSFR_SRC_LSB 5
`define CSFR_PHASE_MSB 4
`define CSFR_PHASE_LSB 3
`define CSFR_PG_BIT 2
`define CSFR_THERM_BIT 1
`define CSFR_MINSYS_BIT 0

// fault_status field positions
`define CSFR_WDOG_BIT 7
`define CSFR_OTG_BIT 6
`define CSFR_CHGF_MSB 5
`define CSFR_CHGF_LSB 4
`define CSFR_BATOV_BIT 3
`define CSFR_ZONE_MSB 2
`define CSFR_ZONE_LSB 0

// input_status_and_irq_masks field positions
`define CSFR_ATTACH_BIT 7
`define CSFR_VREG_BIT 6
`define CSFR_IREG_BIT 5
`define CSFR_RSVD_BIT 4
`define CSFR_TOPOFF_BIT 3
`define CSFR_INOV_BIT 2
`define CSFR_VMASK_BIT 1
`define CSFR_IMASK_BIT 0

// mask reset value
`define CSFR_MASK_RESET 1'b0

// input source codes
`define CSFR_SRC_NONE 3'h0
`define CSFR_SRC_SDP 3'h1
`define CSFR_SRC_CDP 3'h2
`define CSFR_SRC_DCP 3'h3
`define CSFR_SRC_UNKNOWN 3'h5
`define CSFR_SRC_NONSTD 3'h6
`define CSFR_SRC_OTG 3'h7

// charge phase codes
`define CSFR_PH_IDLE 2'h0
`define CSFR_PH_PRE 2'h1
`define CSFR_PH_FAST 2'h2
`define CSFR_PH_DONE 2'h3

// charge fault codes
`define CSFR_CF_NORMAL 2'h0
`define CSFR_CF_INPUT 2'h1
`define CSFR_CF_THERMAL 2'h2
`define CSFR_CF_TIMER 2'h3

// thermistor zone codes
`define CSFR_TZ_NORMAL 3'h0
`define CSFR_TZ_WARM 3'h2
`define CSFR_TZ_COOL 3'h3
`define CSFR_TZ_COLD 3'h5
`define CSFR_TZ_HOT 3'h6

// defaults reload takes this many cycles before the request bit self-clears
`define CSFR_RELOAD_NS 100
`define CSFR_CLK_NS 25
`define CSFR_RELOAD_CYC ((`CSFR_RELOAD_NS + `CSFR_CLK_NS - 1) / `CSFR_CLK_NS)

`endif

// ---- logic/csfr_code_map.v ----
// encoders that turn the analog side's condition levels into the status
// field codes of the bank.
// assumes: inputs are steady levels synchronous to mclk.

`include "csfr_defines.vh"

module csfr_code_map (
  input wire [6:0] source_onehot,
  input wire in_precharge,
  input wire in_fastcharge,
  input wire charge_done,
  input wire adapter_ov,
  input wire vin_between_bat_and_min,
  input wire thermal_shutdown,
  input wire safety_timer_expired,
  input wire boost_mode,
  input wire [3:0] zone_onehot,
  output reg [2:0] source_code,
  output reg [1:0] phase_code,
  output reg [1:0] fault_code,
  output reg [2:0] zone_code
);

  ////////////////////////////////////////////////////////////////////////////
  // source: bit order sdp,cdp,dcp,unknown,nonstd,otg; otg wins; bit 6 spare
  always @* begin
    source_code = `CSFR_SRC_NONE;
    if (source_onehot[5]) begin
      source_code = `CSFR_SRC_OTG;
    end else if (source_onehot[4]) begin
      source_code = `CSFR_SRC_NONSTD;
    end else if (source_onehot[3]) begin
      source_code = `CSFR_SRC_UNKNOWN;
    end else if (source_onehot[2]) begin
      source_code = `CSFR_SRC_DCP;
    end else if (source_onehot[1]) begin
      source_code = `CSFR_SRC_CDP;
    end else if (source_onehot[0]) begin
      source_code = `CSFR_SRC_SDP;
    end
  end

  // charge phase, termination outranks fast outranks pre-charge
  always @* begin
    phase_code = `CSFR_PH_IDLE;
    if (charge_done) begin
      phase_code = `CSFR_PH_DONE;
    end else if (in_fastcharge) begin
      phase_code = `CSFR_PH_FAST;
    end else if (in_precharge) begin
      phase_code = `CSFR_PH_PRE;
    end
  end

  // charge fault; the timer code is the most severe shown
  always @* begin
    fault_code = `CSFR_CF_NORMAL;
    if (safety_timer_expired) begin
      fault_code = `CSFR_CF_TIMER;
    end else if (thermal_shutdown) begin
      fault_code = `CSFR_CF_THERMAL;
    end else if (adapter_ov || vin_between_bat_and_min) begin
      fault_code = `CSFR_CF_INPUT;
    end
  end

  // zone order: warm, cool, cold, hot; boost mode drops warm and cool
  always @* begin
    zone_code = `CSFR_TZ_NORMAL;
    if (zone_onehot[3]) begin
      zone_code = `CSFR_TZ_HOT;
    end else if (zone_onehot[2]) begin
      zone_code = `CSFR_TZ_COLD;
    end else if (!boost_mode && zone_onehot[1]) begin
      zone_code = `CSFR_TZ_COOL;
    end else if (!boost_mode && zone_onehot[0]) begin
      zone_code = `CSFR_TZ_WARM;
    end
  end

endmodule

// ---- logic/csfr_irq_pulse.v ----
// one-cycle pulse on the rising edge of a regulation level, gated by a mask.
// assumes: level synchronous to mclk.

module csfr_irq_pulse (
  input wire mclk,
  input wire rst_n,
  input wire level,
  input wire mask,
  output wire pulse
);

  reg level_q; // previous level
  wire level_d;

  assign level_d = level;

  // remember the level so an entry can be seen as a rising edge
  always @(posedge mclk) begin
    if (!rst_n) begin
      level_q <= 1'b0;
    end else begin
      level_q <= level_d;
    end
  end

  // mask set means no pulse; a level already high at reset still gives one, since level_q resets low
  assign pulse = level && !level_q && !mask;

endmodule

// ---- dv/csfr_status_regs_asserts.sv ----
// concurrent checks on the status and fault register bank ports.
// assumes: bound to csfr_status_regs; one clock, sync active low reset.
module csfr_status_regs_chk #(
  parameter RELOAD_CYC = 4
) (
  input wire mclk,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire reg_hit,
  input wire reload_request,
  input wire reload_busy,
  input wire safety_timer_reset,
  input wire power_good,
  input wire watchdog_expired,
  input wire input_attached,
  input wire in_vin_regulation,
  input wire vin_reg_irq,
  input wire iin_reg_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // busy length counter, so the reload span is judged against the parameter
  logic [7:0] busy_len_q;
  always @(posedge mclk) begin
    if (!rst_n) busy_len_q <= 8'h00;
    else if (reload_busy) busy_len_q <= busy_len_q + 8'h01;
    else busy_len_q <= 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  a_unmapped_reads_zero: assert property (
    reg_rd && !reg_hit |=> reg_rdata == 8'h00)
    else $error("unmapped read returned nonzero data");
  // status reads lag the condition by two flop stages, the capture flop and the read data flop
  a_power_good_bit: assert property (
    reg_rd && reg_addr == 8'h08 && $past(rst_n)
    |=> reg_rdata[2] == $past(power_good, 2))
    else $error("power good bit wrong");
  a_watchdog_bit: assert property (
    reg_rd && reg_addr == 8'h09 && $past(rst_n)
    |=> reg_rdata[7] == $past(watchdog_expired, 2))
    else $error("watchdog bit wrong");
  a_attach_bit: assert property (
    reg_rd && reg_addr == 8'h0a && $past(rst_n)
    |=> reg_rdata[7] == $past(input_attached, 2))
    else $error("input attached bit wrong");
  a_vin_irq_cause: assert property (
    vin_reg_irq && $past(rst_n, 2)
    |-> $past(in_vin_regulation) && !$past(in_vin_regulation, 2))
    else $error("voltage irq without a rising regulation level");
  a_vin_irq_single: assert property (
    vin_reg_irq |=> !vin_reg_irq)
    else $error("voltage irq longer than one cycle");
  a_iin_irq_single: assert property (
    iin_reg_irq |=> !iin_reg_irq)
    else $error("current irq longer than one cycle");
  a_reload_starts: assert property (
    reload_request && !reload_busy |=> reload_busy && safety_timer_reset)
    else $error("reload did not start busy and timer reset");
  a_reload_length: assert property (
    $fell(reload_busy) |-> busy_len_q == RELOAD_CYC)
    else $error("reload busy span wrong");
  // the hit flag is the host's only sign that an address is mapped
  a_hit_decode: assert property (
    reg_hit == (reg_addr == 8'h08 || reg_addr == 8'h09 || reg_addr == 8'h0a))
    else $error("register hit flag wrong");
  // a stuck timer reset would stall charging long after the reload ends
  a_timer_reset_span: assert property (
    safety_timer_reset == reload_busy)
    else $error("safety timer reset not aligned with reload");
endmodule

bind csfr_status_regs csfr_status_regs_chk #(.RELOAD_CYC(RELOAD_CYC))
  i_csfr_status_regs_chk (
  .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_hit(reg_hit), .reload_request(reload_request),
  .reload_busy(reload_busy), .safety_timer_reset(safety_timer_reset),
  .power_good(power_good), .watchdog_expired(watchdog_expired),
  .input_attached(input_attached), .in_vin_regulation(in_vin_regulation),
  .vin_reg_irq(vin_reg_irq), .iin_reg_irq(iin_reg_irq)
);

// ---- dv/csfr_host_model.sv ----
// host side of the register port: single strobed reads and writes.
// assumes: strobes are taken on the rising mclk edge, data one cycle later.
module csfr_host_model (
  input wire mclk,
  input wire [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // released lines show the inverse so stale values never look valid
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge mclk);
    #1;
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~addr;
    reg_wdata = ~data;
  endtask
  // read data is registered, so it is taken one edge after the strobe
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge mclk);
    #1;
    reg_addr = addr;
    reg_rd = 1'b1;
    @(posedge mclk);
    #1;
    data = reg_rdata;
    reg_rd = 1'b0;
    reg_addr = ~addr;
  endtask
endmodule

// ---- dv/tb_csfr_status_regs.sv ----
// self-checking bench for the charger status and fault register bank.
// assumes: csfr_host_model drives the register port, bench drives levels.
module tb_csfr_status_regs;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RELOAD = 4;
  logic mclk, rst_n, reload_req;
  logic [6:0] src;
  logic [3:0] zone;
  logic [19:0] lv; // one-bit condition levels, indexed as wired below
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, reg_hit, reload_busy, safety_timer_reset;
  wire vin_reg_irq, iin_reg_irq;
  int num_errors = 0;
  int cmp_count = 0;
  csfr_host_model i_csfr_host_model (.mclk(mclk), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd));
  csfr_status_regs #(.RELOAD_CYC(RELOAD)) i_csfr_status_regs (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_hit(reg_hit), .reload_request(reload_req),
    .reload_busy(reload_busy), .safety_timer_reset(safety_timer_reset),
    .source_onehot(src), .in_precharge(lv[0]), .in_fastcharge(lv[1]),
    .charge_done(lv[2]), .power_good(lv[3]),
    .in_thermal_regulation(lv[4]), .in_min_system_regulation(lv[5]),
    .watchdog_expired(lv[6]), .otg_overload(lv[7]),
    .battery_too_low_for_boost(lv[8]), .adapter_ov(lv[9]),
    .vin_between_bat_and_min(lv[10]), .thermal_shutdown(lv[11]),
    .safety_timer_expired(lv[12]), .battery_ov(lv[13]),
    .boost_mode(lv[14]), .zone_onehot(zone), .input_attached(lv[15]),
    .in_vin_regulation(lv[16]), .in_iin_regulation(lv[17]),
    .topoff_counting(lv[18]), .input_ov_state(lv[19]),
    .vin_reg_irq(vin_reg_irq), .iin_reg_irq(iin_reg_irq));
  ////////////////////////////////////////////////////////////////////////////
  // clock at 40 MHz
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp8(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask
  task automatic cmp_n(input string what, input int exp, input int got);
    cmp_count++;
    if (got != exp) begin
      $display("unexpected %s expected %0d seen %0d", what, exp, got);
      num_errors++;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    i_csfr_host_model.read_reg(a, d);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_csfr_host_model.write_reg(a, d);
  endtask
  // one condition alone, whole byte compared, so stray bits are caught
  task automatic check_one(input int idx, input logic [7:0] a,
                           input logic [7:0] exp, input string what);
    logic [7:0] got;
    lv = 20'h0;
    lv[idx] = 1'b1;
    rd(a, got);
    cmp8(what, exp, got);
    lv = 20'h0;
  endtask
  // counts irq pulses while one regulation level is raised and held
  task automatic pulse_count(input int idx, output int n);
    n = 0;
    lv[idx] = 1'b1;
    repeat (6) begin
      @(posedge mclk);
      #1;
      if ((idx == 16 ? vin_reg_irq : iin_reg_irq) === 1'b1) n++;
    end
    lv[idx] = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_source();
    logic [7:0] exp [6] = '{8'h20, 8'h40, 8'h60, 8'ha0, 8'hc0, 8'he0};
    logic [7:0] got;
    for (int i = 0; i < 6; i++) begin
      src = 7'h01 << i;
      rd(8'h08, got);
      cmp8("source code", exp[i], got);
    end
    src = 7'h00;
    rd(8'h08, got);
    cmp8("no source", 8'h00, got);
    $display("test source done");
  endtask
  task automatic t_charger();
    check_one(0, 8'h08, 8'h08, "precharge");
    check_one(1, 8'h08, 8'h10, "fast charge");
    check_one(2, 8'h08, 8'h18, "charge done");
    check_one(3, 8'h08, 8'h04, "power good");
    check_one(4, 8'h08, 8'h02, "thermal regulation");
    check_one(5, 8'h08, 8'h01, "minimum system");
    $display("test charger done");
  endtask
  task automatic t_fault();
    check_one(6, 8'h09, 8'h80, "watchdog");
    check_one(7, 8'h09, 8'h40, "otg overload");
    check_one(8, 8'h09, 8'h40, "battery low for boost");
    check_one(9, 8'h09, 8'h50, "adapter overvoltage");
    check_one(10, 8'h09, 8'h10, "low input");
    check_one(11, 8'h09, 8'h20, "thermal shutdown");
    check_one(12, 8'h09, 8'h30, "safety timer");
    check_one(13, 8'h09, 8'h08, "battery overvoltage");
    $display("test fault done");
  endtask
  task automatic t_zone();
    logic [7:0] buck [4] = '{8'h02, 8'h03, 8'h05, 8'h06};
    logic [7:0] boost [4] = '{8'h00, 8'h00, 8'h05, 8'h06};
    logic [7:0] got;
    for (int i = 0; i < 4; i++) begin
      zone = 4'h1 << i;
      lv[14] = 1'b0;
      rd(8'h09, got);
      cmp8("buck zone", buck[i], got);
      lv[14] = 1'b1;
      rd(8'h09, got);
      cmp8("boost zone", boost[i], got);
    end
    zone = 4'h0;
    lv[14] = 1'b0;
    $display("test zone done");
  endtask
  task automatic t_input();
    check_one(15, 8'h0a, 8'h80, "input attached");
    check_one(16, 8'h0a, 8'h40, "voltage regulation");
    check_one(17, 8'h0a, 8'h20, "current regulation");
    check_one(18, 8'h0a, 8'h08, "topoff running");
    check_one(19, 8'h0a, 8'h04, "input overvoltage");
    $display("test input done");
  endtask
  task automatic t_writes();
    logic [7:0] got;
    rd(8'h0a, got);
    cmp8("masks after reset", 8'h00, got);
    wr(8'h08, 8'hff);
    wr(8'h09, 8'hff);
    wr(8'h0a, 8'hff);
    rd(8'h08, got);
    cmp8("charger after write", 8'h00, got);
    rd(8'h09, got);
    cmp8("fault after write", 8'h00, got);
    rd(8'h0a, got);
    cmp8("masks after write", 8'h03, got);
    rd(8'h0b, got);
    cmp8("unmapped read", 8'h00, got);
    rst_n = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    rd(8'h0a, got);
    cmp8("masks after second reset", 8'h00, got);
    $display("test writes done");
  endtask
  task automatic t_irq();
    int n;
    pulse_count(16, n);
    cmp_n("voltage irq open", 1, n);
    pulse_count(17, n);
    cmp_n("current irq open", 1, n);
    wr(8'h0a, 8'h02);
    pulse_count(16, n);
    cmp_n("voltage irq masked", 0, n);
    pulse_count(17, n);
    cmp_n("current irq beside voltage mask", 1, n);
    wr(8'h0a, 8'h01);
    pulse_count(16, n);
    cmp_n("voltage irq beside current mask", 1, n);
    pulse_count(17, n);
    cmp_n("current irq masked", 0, n);
    $display("test irq done");
  endtask
  task automatic t_reload();
    int n;
    logic [7:0] got;
    wr(8'h0a, 8'h03);
    reload_req = 1'b1;
    @(posedge mclk);
    #1;
    reload_req = 1'b0;
    n = 0;
    repeat (8) begin
      if (reload_busy === 1'b1 && safety_timer_reset === 1'b1) n++;
      @(posedge mclk);
      #1;
    end
    cmp_n("reload busy cycles", RELOAD, n);
    rd(8'h0a, got);
    cmp8("masks after reload", 8'h00, got);
    // a mask write landing while the reload runs must not stick
    wr(8'h0a, 8'h03);
    reload_req = 1'b1;
    wr(8'h0a, 8'h03);
    reload_req = 1'b0;
    repeat (RELOAD) @(posedge mclk);
    #1;
    rd(8'h0a, got);
    cmp8("masks after write in reload", 8'h00, got);
    $display("test reload done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // main sequence, reset held for four cycles
  initial begin
    rst_n = 1'b0;
    reload_req = 1'b0;
    src = 7'h00;
    zone = 4'h0;
    lv = 20'h0;
    repeat (4) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    t_writes();
    t_source();
    t_charger();
    t_fault();
    t_zone();
    t_input();
    t_irq();
    t_reload();
    summarize();
  end
  // watchdog: the tests need well under a thousand cycles
  initial begin
    #75000;
    num_errors++;
    summarize();
  end
endmodule
